// [ce_cond_eval.sv]
// Evaluates one 5-bit condition code for one processing element.
// Assumes the status flags are stable for the cycle; purely combinational.
`default_nettype none
`include "ce_consts.svh"

module ce_cond_eval (
    input wire logic [4:0] code,
    input wire logic do_ctx,
    input wire logic zero_flag,
    input wire logic negative_flag,
    input wire logic overflow_flag,
    input wire logic carry_flag,
    input wire logic float_op_flag,
    input wire logic saturation_enable,
    input wire logic mult_overflow,
    input wire logic mult_sign,
    input wire logic shift_overflow,
    input wire logic shift_zero,
    input wire logic bit_test_result,
    input wire logic [3:0] flag_pins,
    input wire logic bus_master_cond,
    input wire logic loop_count_done,
    output logic cond_true
);
    logic ovf_q;
    logic le_term;
    logic lt_term;
    logic base;

    // In the LT and LE terms, overflow only counts while saturation is off.
    assign ovf_q = overflow_flag & ~saturation_enable;
    assign le_term = (~float_op_flag & (negative_flag ^ ovf_q))
                   | (float_op_flag & negative_flag) | zero_flag;
    assign lt_term = (~float_op_flag & (negative_flag ^ ovf_q))
                   | (float_op_flag & negative_flag & ~zero_flag);

    always_comb begin
        unique case (code[3:0])
            `CE_C_EQ: base = zero_flag;
            `CE_C_LT: base = lt_term;
            `CE_C_LE: base = le_term;
            `CE_C_AC: base = carry_flag;
            `CE_C_AV: base = overflow_flag;
            `CE_C_MV: base = mult_overflow;
            `CE_C_MS: base = mult_sign;
            `CE_C_SV: base = shift_overflow;
            `CE_C_SZ: base = shift_zero;
            `CE_C_F0: base = flag_pins[0];
            `CE_C_F1: base = flag_pins[1];
            `CE_C_F2: base = flag_pins[2];
            `CE_C_F3: base = flag_pins[3];
            `CE_C_TF: base = bit_test_result;
            `CE_C_BM: base = bus_master_cond;
            `CE_C_LCE: base = do_ctx ? loop_count_done : ~loop_count_done;
        endcase
    end

    always_comb begin
        if (code == `CE_C_ALWAYS) begin
            // A loop that never ends needs a test that never fires.
            cond_true = ~do_ctx;
        end else if (code[3:0] == `CE_C_LCE) begin
            cond_true = base;
        end else begin
            cond_true = code[4] ? ~base : base;
        end
    end
endmodule : ce_cond_eval

`default_nettype wire

// [ce_consts.svh]
// Constants for the condition evaluator and instruction field decoder.
// Assumes a 48-bit instruction word; all positions are bit indices into it.
`ifndef CE_CONSTS_SVH
`define CE_CONSTS_SVH

// ==========================================================================
// Widths and fixed values
// ==========================================================================
`define CE_IW 48
`define CE_LCNT_W 32
`define CE_LCNT_ONE 32'h0000_0001
`define CE_FIRST_BANK 4'h0
`define CE_SECOND_BANK 4'h8

// ==========================================================================
// Condition code values
// ==========================================================================
`define CE_C_EQ 4'h0
`define CE_C_LT 4'h1
`define CE_C_LE 4'h2
`define CE_C_AC 4'h3
`define CE_C_AV 4'h4
`define CE_C_MV 4'h5
`define CE_C_MS 4'h6
`define CE_C_SV 4'h7
`define CE_C_SZ 4'h8
`define CE_C_F0 4'h9
`define CE_C_F1 4'ha
`define CE_C_F2 4'hb
`define CE_C_F3 4'hc
`define CE_C_TF 4'hd
`define CE_C_BM 4'he
`define CE_C_LCE 4'hf
`define CE_C_ALWAYS 5'h1f

// ==========================================================================
// Field positions
// ==========================================================================
`define CE_TYPE_HI 47
`define CE_TYPE_LO 45
`define CE_ABORT 44
`define CE_CALL 43
`define CE_ELSE 42
`define CE_DELAY 41
`define CE_IRQCLR 40
`define CE_LONG 39
`define CE_MSEL 38
`define CE_COND_HI 37
`define CE_COND_LO 33
`define CE_DMI_HI 32
`define CE_DMI_LO 30
`define CE_DMM_HI 29
`define CE_DMM_LO 27
`define CE_PMI_HI 26
`define CE_PMI_LO 24
`define CE_PMM_HI 23
`define CE_PMM_LO 21
`define CE_DMDIR 20
`define CE_PMDIR 19
`define CE_UNIT_HI 18
`define CE_UNIT_LO 17
`define CE_MRES_HI 16
`define CE_MRES_LO 13
`define CE_DREG_HI 16
`define CE_DREG_LO 13
`define CE_BOP_HI 12
`define CE_BOP_LO 10
`define CE_CREG_HI 9
`define CE_CREG_LO 5
`define CE_CSEL_HI 4
`define CE_CSEL_LO 3
`define CE_XSEL 2
`define CE_LPU 12
`define CE_LPO 11
`define CE_PPU 10
`define CE_PPO 9
`define CE_LR 8
`define CE_INC 7
`define CE_DEC 6
`define CE_FLUSH 5
`define CE_NUM_HI 2
`define CE_NUM_LO 0

`endif

// [ce_decode.sv]
// Condition evaluation and opcode field decode for the sequencer.
// Assumes the instruction word and status flags are synchronous to clock;
// every result is registered and valid one cycle after its inputs.
`default_nettype none
`include "ce_consts.svh"

module ce_decode (
    input wire logic clock,
    input wire logic reset,
    input wire logic [`CE_IW-1:0] instr,
    input wire logic dual_mode,
    input wire logic [3:0] flag_pins,
    input wire logic bus_master_cond,
    input wire logic [`CE_LCNT_W-1:0] current_loop_count,
    input wire logic saturation_enable,
    input wire logic x_zero_flag,
    input wire logic x_negative_flag,
    input wire logic x_overflow_flag,
    input wire logic x_carry_flag,
    input wire logic x_float_op_flag,
    input wire logic x_mult_overflow,
    input wire logic x_mult_sign,
    input wire logic x_shift_overflow,
    input wire logic x_shift_zero,
    input wire logic x_bit_test_result,
    input wire logic y_zero_flag,
    input wire logic y_negative_flag,
    input wire logic y_overflow_flag,
    input wire logic y_carry_flag,
    input wire logic y_float_op_flag,
    input wire logic y_mult_overflow,
    input wire logic y_mult_sign,
    input wire logic y_shift_overflow,
    input wire logic y_shift_zero,
    input wire logic y_bit_test_result,
    output logic element_x_cond_q,
    output logic element_y_cond_q,
    output logic loop_count_done_q,
    output logic term_done_q,
    output logic element_x_compute_q,
    output logic element_y_compute_q,
    output logic branch_take_q,
    output logic return_take_q,
    output logic call_q,
    output logic delayed_q,
    output logic abort_pop_q,
    output logic irq_clear_bit_q,
    output logic mult_pick_valid_q,
    output logic mult_pick_bg_q,
    output logic [1:0] mult_pick_part_q,
    output logic bitop_valid_q,
    output ce_pkg::ce_bitop_e bit_op_code_q,
    output logic unit_valid_q,
    output ce_pkg::ce_unit_e unit_pick_q,
    output logic [4:0] cache_entry_q,
    output ce_pkg::ce_csel_e cache_half_q,
    output logic cache_half_valid_q,
    output logic cache_flush_bit_q,
    output logic ureg_xfer_q,
    output logic cache_load_q,
    output logic data_mem_dir_q,
    output logic prog_mem_dir_q,
    output logic [3:0] first_gen_index_sel_q,
    output logic [3:0] first_gen_modify_sel_q,
    output logic [3:0] second_gen_index_sel_q,
    output logic [3:0] second_gen_modify_sel_q,
    output logic [3:0] dreg_sel_q,
    output logic mem_sel_second_q,
    output logic long_word_q,
    output logic count_down_bit_q,
    output logic count_up_q,
    output logic loop_stack_push_q,
    output logic loop_stack_pop_q,
    output logic pc_stack_push_q,
    output logic pc_stack_pop_q,
    output logic reenter_bit_q,
    output logic [2:0] irq_vector_q
);
    // ======================================================================
    // Field extraction
    // ======================================================================
    ce_pkg::ce_itype_e itype;
    logic [4:0] cond_code;
    logic else_bit;
    logic loop_count_done;
    logic cond_x;
    logic cond_y;
    logic do_ctx;
    logic both_true;
    logic [3:0] mres;
    logic [2:0] bit_op_code;
    logic [1:0] unit;
    logic [1:0] csel;
    logic is_misc;

    // Only the fixed type bits steer the decode; other bits are don't-care.
    assign itype = ce_pkg::ce_itype_e'(instr[`CE_TYPE_HI:`CE_TYPE_LO]);
    assign cond_code = instr[`CE_COND_HI:`CE_COND_LO];
    assign else_bit = instr[`CE_ELSE];
    assign mres = instr[`CE_MRES_HI:`CE_MRES_LO];
    assign bit_op_code = instr[`CE_BOP_HI:`CE_BOP_LO];
    assign unit = instr[`CE_UNIT_HI:`CE_UNIT_LO];
    assign csel = instr[`CE_CSEL_HI:`CE_CSEL_LO];
    assign is_misc = (itype == ce_pkg::CE_T_MISC);
    assign do_ctx = (itype == ce_pkg::CE_T_DOLOOP);
    assign loop_count_done = (current_loop_count == `CE_LCNT_ONE);

    // Maps a 3-bit selector into the bank that starts at base.
    function automatic logic [3:0] bank_map(input logic [2:0] sel, input logic [3:0] base);
        bank_map = base | {1'b0, sel};
    endfunction : bank_map

    // ======================================================================
    // Per-element condition evaluation
    // ======================================================================
    ce_cond_eval u_eval_x (
        .code(cond_code),
        .do_ctx(do_ctx),
        .zero_flag(x_zero_flag),
        .negative_flag(x_negative_flag),
        .overflow_flag(x_overflow_flag),
        .carry_flag(x_carry_flag),
        .float_op_flag(x_float_op_flag),
        .saturation_enable(saturation_enable),
        .mult_overflow(x_mult_overflow),
        .mult_sign(x_mult_sign),
        .shift_overflow(x_shift_overflow),
        .shift_zero(x_shift_zero),
        .bit_test_result(x_bit_test_result),
        .flag_pins(flag_pins),
        .bus_master_cond(bus_master_cond),
        .loop_count_done(loop_count_done),
        .cond_true(cond_x)
    );

    ce_cond_eval u_eval_y (
        .code(cond_code),
        .do_ctx(do_ctx),
        .zero_flag(y_zero_flag),
        .negative_flag(y_negative_flag),
        .overflow_flag(y_overflow_flag),
        .carry_flag(y_carry_flag),
        .float_op_flag(y_float_op_flag),
        .saturation_enable(saturation_enable),
        .mult_overflow(y_mult_overflow),
        .mult_sign(y_mult_sign),
        .shift_overflow(y_shift_overflow),
        .shift_zero(y_shift_zero),
        .bit_test_result(y_bit_test_result),
        .flag_pins(flag_pins),
        .bus_master_cond(bus_master_cond),
        .loop_count_done(loop_count_done),
        .cond_true(cond_y)
    );

    // In single mode the second element does not exist, so only x decides.
    assign both_true = dual_mode ? (cond_x & cond_y) : cond_x;

    // ======================================================================
    // Conditions and program flow
    // ======================================================================
    logic comp_x_d;
    logic comp_y_d;
    logic flow_d;

    always_comb begin
        comp_x_d = 1'b0;
        comp_y_d = 1'b0;
        flow_d = 1'b0;
        unique case (itype)
            ce_pkg::CE_T_COMPUTE: begin
                comp_x_d = cond_x;
                comp_y_d = dual_mode & cond_y;
            end
            ce_pkg::CE_T_BRANCH, ce_pkg::CE_T_RETURN: begin
                // With else, each element computes on its own false result.
                comp_x_d = else_bit ? ~cond_x : cond_x;
                comp_y_d = dual_mode & (else_bit ? ~cond_y : cond_y);
                flow_d = both_true;
            end
            ce_pkg::CE_T_DOLOOP, ce_pkg::CE_T_BITOP, ce_pkg::CE_T_CACHE,
            ce_pkg::CE_T_NONE, ce_pkg::CE_T_MISC: begin
                comp_x_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            element_x_cond_q <= 1'b0;
            element_y_cond_q <= 1'b0;
            loop_count_done_q <= 1'b0;
            term_done_q <= 1'b0;
            element_x_compute_q <= 1'b0;
            element_y_compute_q <= 1'b0;
        end else begin
            element_x_cond_q <= cond_x;
            element_y_cond_q <= dual_mode & cond_y;
            loop_count_done_q <= loop_count_done;
            term_done_q <= do_ctx & cond_x;
            element_x_compute_q <= comp_x_d;
            element_y_compute_q <= comp_y_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            branch_take_q <= 1'b0;
            return_take_q <= 1'b0;
            call_q <= 1'b0;
            delayed_q <= 1'b0;
            abort_pop_q <= 1'b0;
            irq_clear_bit_q <= 1'b0;
        end else begin
            branch_take_q <= flow_d & (itype == ce_pkg::CE_T_BRANCH);
            return_take_q <= flow_d & (itype == ce_pkg::CE_T_RETURN);
            call_q <= instr[`CE_CALL];
            delayed_q <= instr[`CE_DELAY];
            // Stacks unwind only when the branch is really taken.
            abort_pop_q <= flow_d & (itype == ce_pkg::CE_T_BRANCH) & instr[`CE_ABORT];
            irq_clear_bit_q <= flow_d & instr[`CE_IRQCLR];
        end
    end

    // ======================================================================
    // Operand and unit fields
    // ======================================================================
    always_ff @(posedge clock) begin
        if (reset) begin
            mult_pick_valid_q <= 1'b0;
            mult_pick_bg_q <= 1'b0;
            mult_pick_part_q <= 2'h0;
            bitop_valid_q <= 1'b0;
            bit_op_code_q <= ce_pkg::CE_B_SET;
            unit_valid_q <= 1'b0;
            unit_pick_q <= ce_pkg::CE_U_ALU;
        end else begin
            // Codes xx11 and 1xxx name no result part and are flagged invalid.
            mult_pick_valid_q <= ~mres[3] & (mres[1:0] != 2'h3);
            mult_pick_bg_q <= mres[2];
            mult_pick_part_q <= mres[1:0];
            bitop_valid_q <= (itype == ce_pkg::CE_T_BITOP) & (bit_op_code != 3'h3)
                           & (bit_op_code[2:1] != 2'h3);
            bit_op_code_q <= ce_pkg::ce_bitop_e'(bit_op_code);
            unit_valid_q <= (unit != 2'h3);
            unit_pick_q <= ce_pkg::ce_unit_e'(unit);
        end
    end

    // ======================================================================
    // Cache access and transfer select
    // ======================================================================
    always_ff @(posedge clock) begin
        if (reset) begin
            cache_entry_q <= 5'h00;
            cache_half_q <= ce_pkg::CE_S_LOWER;
            cache_half_valid_q <= 1'b0;
            cache_flush_bit_q <= 1'b0;
            ureg_xfer_q <= 1'b0;
            cache_load_q <= 1'b0;
        end else begin
            cache_entry_q <= instr[`CE_CREG_HI:`CE_CREG_LO];
            cache_half_q <= ce_pkg::ce_csel_e'(csel);
            cache_half_valid_q <= (itype == ce_pkg::CE_T_CACHE) & (csel != 2'h2);
            cache_flush_bit_q <= is_misc & instr[`CE_FLUSH];
            ureg_xfer_q <= (itype == ce_pkg::CE_T_CACHE) & instr[`CE_XSEL];
            cache_load_q <= (itype == ce_pkg::CE_T_CACHE) & ~instr[`CE_XSEL];
        end
    end

    // ======================================================================
    // Memory access fields
    // ======================================================================
    always_ff @(posedge clock) begin
        if (reset) begin
            data_mem_dir_q <= 1'b0;
            prog_mem_dir_q <= 1'b0;
            first_gen_index_sel_q <= 4'h0;
            first_gen_modify_sel_q <= 4'h0;
            second_gen_index_sel_q <= 4'h8;
            second_gen_modify_sel_q <= 4'h8;
            dreg_sel_q <= 4'h0;
            mem_sel_second_q <= 1'b0;
            long_word_q <= 1'b0;
        end else begin
            data_mem_dir_q <= instr[`CE_DMDIR];
            prog_mem_dir_q <= instr[`CE_PMDIR];
            first_gen_index_sel_q <= bank_map(instr[`CE_DMI_HI:`CE_DMI_LO],
                                              `CE_FIRST_BANK);
            first_gen_modify_sel_q <= bank_map(instr[`CE_DMM_HI:`CE_DMM_LO],
                                               `CE_FIRST_BANK);
            second_gen_index_sel_q <= bank_map(instr[`CE_PMI_HI:`CE_PMI_LO],
                                               `CE_SECOND_BANK);
            second_gen_modify_sel_q <= bank_map(instr[`CE_PMM_HI:`CE_PMM_LO],
                                                `CE_SECOND_BANK);
            dreg_sel_q <= instr[`CE_DREG_HI:`CE_DREG_LO];
            mem_sel_second_q <= instr[`CE_MSEL];
            // Low means the memory map region decides the width downstream.
            long_word_q <= instr[`CE_LONG];
        end
    end

    // ======================================================================
    // Stack, counter and vector operations
    // ======================================================================
    // These bits share positions with compute fields, so all but the vector number act only for
    // the miscellaneous type; elsewhere they would fire spuriously.
    always_ff @(posedge clock) begin
        if (reset) begin
            count_down_bit_q <= 1'b0;
            count_up_q <= 1'b0;
            loop_stack_push_q <= 1'b0;
            loop_stack_pop_q <= 1'b0;
            pc_stack_push_q <= 1'b0;
            pc_stack_pop_q <= 1'b0;
            reenter_bit_q <= 1'b0;
            irq_vector_q <= 3'h0;
        end else begin
            count_down_bit_q <= is_misc & instr[`CE_DEC];
            count_up_q <= is_misc & instr[`CE_INC];
            loop_stack_push_q <= is_misc & instr[`CE_LPU];
            loop_stack_pop_q <= is_misc & instr[`CE_LPO];
            pc_stack_push_q <= is_misc & instr[`CE_PPU];
            pc_stack_pop_q <= is_misc & instr[`CE_PPO];
            reenter_bit_q <= is_misc & instr[`CE_LR];
            irq_vector_q <= instr[`CE_NUM_HI:`CE_NUM_LO];
        end
    end
endmodule : ce_decode

`default_nettype wire

// [ce_decode_props.sv]
// Checker for ce_decode: each result against the inputs one edge earlier.
// Assumes it is bound to ce_decode and sees only that module's ports.
`default_nettype none
`include "ce_consts.svh"

module ce_decode_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic [`CE_IW-1:0] instr,
    input wire logic dual_mode,
    input wire logic [`CE_LCNT_W-1:0] current_loop_count,
    input wire logic element_x_cond_q,
    input wire logic element_y_cond_q,
    input wire logic element_x_compute_q,
    input wire logic branch_take_q,
    input wire logic return_take_q,
    input wire logic abort_pop_q,
    input wire logic loop_count_done_q,
    input wire logic [3:0] first_gen_index_sel_q,
    input wire logic [3:0] second_gen_index_sel_q,
    input wire logic loop_stack_push_q
);
    // ========================================
    // Properties
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // The guard on the previous reset keeps reset values out of every comparison but chk_both_elements and chk_reset_vals.
    chk_loop_done: assert property (
        !$past(reset) |-> loop_count_done_q == ($past(current_loop_count) == `CE_LCNT_ONE))
        else $error("loop done wrong");
    chk_both_elements: assert property (
        branch_take_q && $past(dual_mode) |-> element_x_cond_q && element_y_cond_q)
        else $error("dual branch taken without both elements");
    chk_single_return: assert property (
        !$past(reset) && $past(instr[47:45]) == 3'h2 && !$past(dual_mode) |->
        return_take_q == element_x_cond_q &&
        element_x_compute_q == (element_x_cond_q ^ $past(instr[`CE_ELSE])))
        else $error("single return table wrong");
    chk_abort_pop: assert property (
        !$past(reset) |-> abort_pop_q == (branch_take_q && $past(instr[`CE_ABORT])))
        else $error("abort pop wrong");
    chk_gen_banks: assert property (
        !$past(reset) |-> first_gen_index_sel_q == {1'b0, $past(instr[32:30])} &&
        second_gen_index_sel_q == {1'b1, $past(instr[26:24])})
        else $error("generator bank wrong");
    chk_stack_push: assert property (
        !$past(reset) |->
        loop_stack_push_q == ($past(instr[47:45]) == 3'h7 && $past(instr[`CE_LPU])))
        else $error("loop push wrong");
    chk_always_true: assert property (
        !$past(reset) && $past(instr[37:33]) == `CE_C_ALWAYS && $past(instr[47:45]) != 3'h3
        |-> element_x_cond_q)
        else $error("always true not true");
    chk_single_y: assert property (
        !$past(reset) && !$past(dual_mode) |-> !element_y_cond_q)
        else $error("y condition in single mode");
    chk_reset_vals: assert property (
        disable iff (1'b0) reset |=> second_gen_index_sel_q == `CE_SECOND_BANK && !branch_take_q)
        else $error("reset values wrong");
endmodule : ce_decode_props

bind ce_decode ce_decode_props ce_decode_props_i (.*);

`default_nettype wire

// [ce_decode_test.sv]
// Self-checking bench for ce_decode: random instructions and status, one a cycle.
// Assumes ce_decode_props.sv is compiled with it and binds itself to the design.
`default_nettype none
`include "ce_consts.svh"

module ce_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] ty;
        logic ex, ey, xc, br, rt, ab, ic, td, lcd, bv, lp, ca, dl;
        logic [3:0] g1, g2;
    } ce_exp_s;
    logic clock, reset, dual_mode, bus_master_cond, saturation_enable;
    logic [`CE_IW-1:0] instr;
    logic [3:0] flag_pins, first_gen_index_sel_q, first_gen_modify_sel_q, dreg_sel_q;
    logic [3:0] second_gen_index_sel_q, second_gen_modify_sel_q;
    logic [`CE_LCNT_W-1:0] current_loop_count;
    logic x_zero_flag, x_negative_flag, x_overflow_flag, x_carry_flag, x_float_op_flag;
    logic x_mult_overflow, x_mult_sign, x_shift_overflow, x_shift_zero, x_bit_test_result;
    logic y_zero_flag, y_negative_flag, y_overflow_flag, y_carry_flag, y_float_op_flag;
    logic y_mult_overflow, y_mult_sign, y_shift_overflow, y_shift_zero, y_bit_test_result;
    logic element_x_cond_q, element_y_cond_q, loop_count_done_q, term_done_q, call_q;
    logic element_x_compute_q, element_y_compute_q, branch_take_q, return_take_q, delayed_q;
    logic abort_pop_q, irq_clear_bit_q, mult_pick_valid_q, mult_pick_bg_q, bitop_valid_q;
    logic unit_valid_q, cache_half_valid_q, cache_flush_bit_q, ureg_xfer_q, cache_load_q;
    logic data_mem_dir_q, prog_mem_dir_q, mem_sel_second_q, long_word_q, count_down_bit_q;
    logic count_up_q, loop_stack_push_q, loop_stack_pop_q, pc_stack_push_q, pc_stack_pop_q;
    logic reenter_bit_q;
    logic [1:0] mult_pick_part_q;
    logic [4:0] cache_entry_q;
    logic [2:0] irq_vector_q;
    ce_pkg::ce_bitop_e bit_op_code_q;
    ce_pkg::ce_unit_e unit_pick_q;
    ce_pkg::ce_csel_e cache_half_q;
    ce_exp_s exp_q[$];
    ce_exp_s e;
    int errors = 0;
    int checked = 0;

    ce_decode ce_decode_i (.*);

    // ========================================
    // Reference and drivers
    // Flag vector order: zero, negative, overflow, carry, float, mult ovf, mult sign,
    // shift ovf, shift zero, bit test.
    function automatic logic cond_ref(input logic [4:0] c, input logic do_ty,
                                      input logic [9:0] f);
        logic sn, base;
        sn = ~f[5] & (f[8] ^ (f[7] & ~saturation_enable));
        if (c == `CE_C_ALWAYS) return !do_ty;
        if (c[3:0] == 4'hf) return do_ty == (current_loop_count == `CE_LCNT_ONE);
        case (c[3:0])
            4'h0: base = f[9];
            4'h1: base = sn | (f[5] & f[8] & ~f[9]);
            4'h2: base = sn | (f[5] & f[8]) | f[9];
            4'h3: base = f[6];
            4'h4: base = f[7];
            4'h5, 4'h6, 4'h7, 4'h8: base = f[4'h9 - c[3:0]];
            4'h9, 4'ha, 4'hb, 4'hc: base = flag_pins[c[1:0] - 2'h1];
            4'hd: base = f[0];
            default: base = bus_master_cond;
        endcase
        return base ^ c[4];
    endfunction : cond_ref

    task automatic set_flags(input logic [9:0] xf, input logic [9:0] yf);
        {x_zero_flag, x_negative_flag, x_overflow_flag, x_carry_flag, x_float_op_flag,
         x_mult_overflow, x_mult_sign, x_shift_overflow, x_shift_zero, x_bit_test_result} = xf;
        {y_zero_flag, y_negative_flag, y_overflow_flag, y_carry_flag, y_float_op_flag,
         y_mult_overflow, y_mult_sign, y_shift_overflow, y_shift_zero, y_bit_test_result} = yf;
    endtask : set_flags

    task automatic step(input logic [2:0] ty, input logic [4:0] c);
        logic [9:0] xf, yf;
        ce_exp_s n;
        logic fl;
        @(negedge clock);
        xf = 10'($urandom);
        yf = 10'($urandom);
        set_flags(xf, yf);
        instr = 48'({$urandom, $urandom});
        instr[47:45] = ty;
        instr[37:33] = c;
        {dual_mode, bus_master_cond, saturation_enable, flag_pins} = 7'($urandom);
        current_loop_count = 32'($urandom_range(2));
        n.ty = ty;
        n.ex = cond_ref(c, ty == 3'h3, xf);
        n.ey = dual_mode & cond_ref(c, ty == 3'h3, yf);
        fl = n.ex & (n.ey | ~dual_mode);
        n.xc = (instr[`CE_ELSE] && ty != 3'h0) ? ~n.ex : n.ex;
        n.br = ty == 3'h1 & fl;
        n.rt = ty == 3'h2 & fl;
        n.ab = n.br & instr[`CE_ABORT];
        n.ca = instr[`CE_CALL];
        n.dl = instr[`CE_DELAY];
        n.ic = (n.br | n.rt) & instr[`CE_IRQCLR];
        n.td = ty == 3'h3 & n.ex;
        n.lcd = current_loop_count == `CE_LCNT_ONE;
        n.bv = ty == 3'h4 && instr[12:10] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
        n.lp = ty == 3'h7 & instr[`CE_LPU];
        n.g1 = {1'b0, instr[32:30]};
        n.g2 = {1'b1, instr[26:24]};
        exp_q.push_back(n);
    endtask : step

    task automatic cmp(input string what, input logic [3:0] want, input logic [3:0] got);
        checked++;
        if (got !== want) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, want, got);
        end
    endtask : cmp

    task automatic wrap_up();
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // ========================================
    // Monitor: outputs settle just after the edge that follows each drive.
    always @(posedge clock) begin
        if (exp_q.size() != 0) begin
            #1;
            e = exp_q.pop_front();
            cmp("x cond", e.ex, element_x_cond_q);
            cmp("y cond", e.ey, element_y_cond_q);
            cmp("loop done", e.lcd, loop_count_done_q);
            cmp("branch", e.br, branch_take_q);
            cmp("term", e.td, term_done_q);
            cmp("bitop valid", e.bv, bitop_valid_q);
            cmp("loop push", e.lp, loop_stack_push_q);
            cmp("call", e.ca, call_q);
            cmp("delay", e.dl, delayed_q);
            cmp("gen one", e.g1, first_gen_index_sel_q);
            cmp("gen two", e.g2, second_gen_index_sel_q);
            if (e.ty < 3'h3) cmp("x compute", e.xc, element_x_compute_q);
            if (e.ty == 3'h1 || e.ty == 3'h2) begin
                cmp("return", e.rt, return_take_q);
                cmp("abort pop", e.ab, abort_pop_q);
                cmp("irq clear", e.ic, irq_clear_bit_q);
            end
        end
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (2000) @(posedge clock);
        errors++;
        wrap_up();
    end

    initial begin
        reset = 1'b1;
        instr = '0;
        {dual_mode, bus_master_cond, saturation_enable, flag_pins} = 7'h00;
        current_loop_count = '0;
        set_flags(10'h000, 10'h000);
        void'($urandom(32'hf6e0));
        repeat (4) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        // Every type against every condition code, then a random tail.
        for (int i = 0; i < 256; i++) step(3'(i / 32), 5'(i));
        for (int i = 0; i < 200; i++) step(3'($urandom), 5'($urandom));
        repeat (2) @(negedge clock);
        wrap_up();
    end
endmodule : ce_decode_test

`default_nettype wire

// [ce_pkg.sv]
// Types shared by the condition evaluator and the field decoder.
// Assumes nothing of its surroundings.
`default_nettype none

package ce_pkg;
    typedef enum logic [2:0] {
        CE_T_COMPUTE = 3'h0,
        CE_T_BRANCH = 3'h1,
        CE_T_RETURN = 3'h2,
        CE_T_DOLOOP = 3'h3,
        CE_T_BITOP = 3'h4,
        CE_T_CACHE = 3'h5,
        CE_T_NONE = 3'h6,
        CE_T_MISC = 3'h7
    } ce_itype_e;

    typedef enum logic [2:0] {
        CE_B_SET = 3'h0,
        CE_B_CLR = 3'h1,
        CE_B_TGL = 3'h2,
        CE_B_TST = 3'h4,
        CE_B_XOR = 3'h5
    } ce_bitop_e;

    typedef enum logic [1:0] {
        CE_U_ALU = 2'h0,
        CE_U_MUL = 2'h1,
        CE_U_SHF = 2'h2
    } ce_unit_e;

    typedef enum logic [1:0] {
        CE_S_LOWER = 2'h0,
        CE_S_UPPER = 2'h1,
        CE_S_TAG = 2'h3
    } ce_csel_e;
endpackage : ce_pkg

`default_nettype wire
